//--- design/ivp_pkg.sv
// Purpose: Shared constants for the interrupt vector placement block.
// Assumes: Word-addressed program flash, 32-bit classic Wishbone register bus.
// Notes: Register offsets, control bit positions, the control reset value and the window length live here.
`default_nettype none
package ivp_pkg;
   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   // Byte address of the vector control register.
   localparam logic [3:0] IVP_VCR_ADDR = 4'h0;
   // Byte address of the fuse and lock status register.
   localparam logic [3:0] IVP_STAT_ADDR = 4'h4;
   // Byte address of the vector base readback register.
   localparam logic [3:0] IVP_BASE_ADDR = 4'h8;
   // Bit position of the change-enable bit.
   localparam int IVP_CE_BIT = 0;
   // Bit position of the vector select bit.
   localparam int IVP_SEL_BIT = 1;
   // Value of the control register after reset.
   localparam logic [7:0] IVP_VCR_RST = 8'h00;
   // ----------------------------------------------------------------------
   // Timing and addresses
   // ----------------------------------------------------------------------
   // Cycles that the change-enable window stays open.
   localparam logic [2:0] IVP_CE_CYCLES = 3'h4;
   // Address width of program flash in words.
   localparam int IVP_AW = 12;
   // Reset vector address when the boot reset fuse is unprogrammed.
   localparam logic [11:0] IVP_APP_RESET = 12'h000;
   // Offset of the first interrupt vector from a table base.
   localparam logic [11:0] IVP_VEC_OFS = 12'h001;
   // Boot section start for each boot size fuse code, 2K byte code is 2'h0.
   localparam logic [11:0] IVP_BOOT_2K = 12'hC00;
   localparam logic [11:0] IVP_BOOT_1K = 12'hE00;
   localparam logic [11:0] IVP_BOOT_512 = 12'hF00;
   localparam logic [11:0] IVP_BOOT_256 = 12'hF80;
endpackage : ivp_pkg
`default_nettype wire

//--- design/ivp_ctl_if.sv
// Purpose: Carries the sequencer state between top and change sequencer.
// Assumes: One clock domain.
// Notes: The top owns register writes, the sequencer owns the window.
`default_nettype none
interface ivp_ctl_if;
   logic wr_ce;     // Write with change-enable bit one.
   logic wr_sel;    // Write with change-enable bit zero.
   logic win_open;  // Change window is open.
   logic blocking;  // Automatic interrupt block is active.
   logic sel_take;  // Select write accepted this cycle.
   modport top (output wr_ce, output wr_sel, input win_open, input blocking, input sel_take);
   modport seq (input wr_ce, input wr_sel, output win_open, output blocking, output sel_take);
endinterface : ivp_ctl_if
`default_nettype wire

//--- design/ivp_seq.sv
// Purpose: Runs the protected two-step change window and the interrupt block.
// Assumes: Writes arrive as one-cycle pulses from the bus slave.
// Notes: The block holds one extra cycle past a select write for the next instruction.
`default_nettype none
module ivp_seq (
   input wire logic clk_sys,
   input wire logic srst,
   ivp_ctl_if.seq ctl
);
   // Cycles left in the change window.
   logic [2:0] cnt_ff;
   // Post-select hold for the instruction that follows the write.
   logic hold_ff;

   // A select write counts only inside an open window.
   assign ctl.win_open = (cnt_ff != 3'h0);
   assign ctl.sel_take = ctl.wr_sel && ctl.win_open;
   assign ctl.blocking = ctl.win_open || hold_ff;

   // Window counter: opens on enable write, closes on timeout or select.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cnt_ff <= 3'h0;
      end else if (ctl.sel_take) begin
         cnt_ff <= 3'h0;
      end else if (ctl.wr_ce) begin
         cnt_ff <= ivp_pkg::IVP_CE_CYCLES;
      end else if (cnt_ff != 3'h0) begin
         cnt_ff <= cnt_ff - 3'h1;
      end
   end

   // Hold the block for one cycle after an accepted select write.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         hold_ff <= 1'b0;
      end else begin
         hold_ff <= ctl.sel_take;
      end
   end

   // Window expires four cycles after opening with no select write.
   a_win_timeout: assert property (@(posedge clk_sys) disable iff (srst)
      (ctl.wr_ce && !ctl.sel_take) ##1 (!ctl.wr_sel && !ctl.wr_ce) [*4] |=> !ctl.win_open)
      else $error("Change window did not close after four cycles.");
   // Select accepted closes the window at once.
   a_sel_closes: assert property (@(posedge clk_sys) disable iff (srst)
      ctl.sel_take && !ctl.wr_ce |=> !ctl.win_open ##0 ctl.blocking ##1 !ctl.blocking || ctl.win_open)
      else $error("Select write did not close the window.");
   c_timeout: cover property (@(posedge clk_sys)
      ctl.wr_ce ##1 ctl.win_open [*4] ##1 !ctl.win_open);
   c_sel_taken: cover property (@(posedge clk_sys) ctl.wr_ce ##[1:4] ctl.sel_take);
endmodule : ivp_seq
`default_nettype wire

//--- design/ivp_top.sv
// Purpose: Interrupt vector placement with a protected select change.
// Assumes: Classic Wishbone slave, fuses and lock bits are static inputs.
// Notes: The core presents a vector index and receives the word address.
//
// What this block does
// - Select zero: vectors at flash start
// - Select one: vectors at boot start
// - Boot start from boot size fuses
// - Enable clears after four or select
// - Block interrupts from enable set onward
// - No select: unblock after four cycles
// - Global interrupt flag left untouched
// - Boot vectors, app lock: app blocked
// - App vectors, boot lock: boot blocked
// - Enable bit zero, select bit one
// - 2K boot section starts at C00
// - Relocated vector equals base plus index
// - Reset vector from boot fuse
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`default_nettype none
module ivp_top (
   input wire logic clk_sys,
   input wire logic srst,
   // Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // Fuses and lock bits, programmed reads as zero.
   input wire logic boot_reset_fuse,
   input wire logic [1:0] boot_size_fuses,
   input wire logic app_interrupt_lock_bit,
   input wire logic boot_interrupt_lock_bit,
   // Core side.
   input wire logic exec_in_boot,
   input wire logic global_int_enable,
   input wire logic [4:0] vector_index,
   output logic [11:0] vector_addr,
   output logic [11:0] reset_addr,
   output logic int_allow,
   output logic vector_select
);
   // ----------------------------------------------------------------------
   // Decode and state
   // ----------------------------------------------------------------------
   ivp_ctl_if ctl ();
   // Stored select bit.
   logic sel_ff;
   // Ack register for the single cycle answer.
   logic ack_ff;
   // Error register for unmapped addresses.
   logic err_ff;
   // Read data register.
   logic [31:0] rdat_ff;
   // Request seen this cycle and not yet answered.
   logic req;
   // Write to the control register with its low byte lane enabled.
   logic vcr_wr;
   // Current boot section start.
   logic [11:0] boot_start;
   // Current vector table base.
   logic [11:0] tbl_base;
   // Suppression by lock bits.
   logic lock_block;

   // Maps a boot size code to the boot section start.
   function automatic logic [11:0] boot_base(input logic [1:0] code);
      case (code)
         2'h0: boot_base = ivp_pkg::IVP_BOOT_2K;
         2'h1: boot_base = ivp_pkg::IVP_BOOT_1K;
         2'h2: boot_base = ivp_pkg::IVP_BOOT_512;
         default: boot_base = ivp_pkg::IVP_BOOT_256;
      endcase
   endfunction : boot_base

   // Tells whether an address is one of the mapped registers.
   function automatic logic is_mapped(input logic [3:0] a);
      is_mapped = (a == ivp_pkg::IVP_VCR_ADDR) || (a == ivp_pkg::IVP_STAT_ADDR)
         || (a == ivp_pkg::IVP_BASE_ADDR);
   endfunction : is_mapped

   assign req = wb_cyc_i && wb_stb_i && !ack_ff && !err_ff;
   assign vcr_wr = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == ivp_pkg::IVP_VCR_ADDR);
   assign ctl.wr_ce = vcr_wr && wb_dat_i[ivp_pkg::IVP_CE_BIT];
   assign ctl.wr_sel = vcr_wr && !wb_dat_i[ivp_pkg::IVP_CE_BIT];

   ivp_seq u_seq (
      .clk_sys(clk_sys),
      .srst(srst),
      .ctl(ctl)
   );

   // ----------------------------------------------------------------------
   // Placement
   // ----------------------------------------------------------------------
   // fuse-derived start
   assign boot_start = boot_base(boot_size_fuses);
   assign tbl_base = sel_ff ? boot_start : 12'h000;
   assign vector_addr = tbl_base + {7'h00, vector_index};
   assign reset_addr = boot_reset_fuse ? ivp_pkg::IVP_APP_RESET : boot_start;
   assign lock_block = (sel_ff && !app_interrupt_lock_bit && !exec_in_boot)
      || (!sel_ff && !boot_interrupt_lock_bit && exec_in_boot);
   assign int_allow = global_int_enable && !ctl.blocking && !lock_block;
   assign vector_select = sel_ff;

   // Select register updates only on an accepted select write.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sel_ff <= ivp_pkg::IVP_VCR_RST[ivp_pkg::IVP_SEL_BIT];
      end else if (ctl.sel_take) begin
         sel_ff <= wb_dat_i[ivp_pkg::IVP_SEL_BIT];
      end
   end

   // ----------------------------------------------------------------------
   // Bus answer
   // ----------------------------------------------------------------------
   // One-cycle ack or error, dropped the cycle after.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ack_ff <= 1'b0;
         err_ff <= 1'b0;
      end else begin
         ack_ff <= req && is_mapped(wb_adr_i);
         err_ff <= req && !is_mapped(wb_adr_i);
      end
   end

   // Read data captured with the request.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rdat_ff <= 32'h0000_0000;
      end else if (req && !wb_we_i) begin
         case (wb_adr_i)
            ivp_pkg::IVP_VCR_ADDR: rdat_ff <= {30'h0, sel_ff, ctl.win_open};
            ivp_pkg::IVP_STAT_ADDR: rdat_ff <= {26'h0, ctl.blocking, lock_block,
               boot_interrupt_lock_bit, app_interrupt_lock_bit, boot_size_fuses};
            ivp_pkg::IVP_BASE_ADDR: rdat_ff <= {4'h0, reset_addr, 4'h0, tbl_base};
            default: rdat_ff <= 32'h0000_0000;
         endcase
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_err_o = err_ff;
   assign wb_dat_o = rdat_ff;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   a_app_table: assert property (@(posedge clk_sys) disable iff (srst)
      !sel_ff |-> vector_addr == {7'h00, vector_index})
      else $error("Application vector address wrong.");
   a_boot_table: assert property (@(posedge clk_sys) disable iff (srst)
      sel_ff && boot_size_fuses == 2'h0 |-> vector_addr == 12'hC00 + {7'h00, vector_index})
      else $error("Boot vector address wrong.");
   a_block_set: assert property (@(posedge clk_sys) disable iff (srst)
      ctl.wr_ce |=> !int_allow [*2])
      else $error("Interrupts not blocked after enable write.");
   a_flag_kept: assert property (@(posedge clk_sys) disable iff (srst)
      !global_int_enable |-> !int_allow)
      else $error("Interrupts allowed without global flag.");
   a_sel_ignored: assert property (@(posedge clk_sys) disable iff (srst)
      ctl.wr_sel && !ctl.win_open |=> $stable(sel_ff))
      else $error("Select changed outside window.");
   a_reset_vec: assert property (@(posedge clk_sys) disable iff (srst)
      boot_reset_fuse |-> reset_addr == 12'h000)
      else $error("Reset vector wrong.");
   a_app_lock: assert property (@(posedge clk_sys) disable iff (srst)
      sel_ff && !app_interrupt_lock_bit && !exec_in_boot |-> !int_allow)
      else $error("Application lock not honoured.");
   a_boot_lock: assert property (@(posedge clk_sys) disable iff (srst)
      !sel_ff && !boot_interrupt_lock_bit && exec_in_boot |-> !int_allow)
      else $error("Boot lock not honoured.");
   a_ack_drop: assert property (@(posedge clk_sys) disable iff (srst)
      wb_ack_o |=> !wb_ack_o)
      else $error("Ack held for two cycles.");
   c_move_boot: cover property (@(posedge clk_sys) !sel_ff ##1 sel_ff);
   c_move_app: cover property (@(posedge clk_sys) sel_ff ##1 !sel_ff);
   c_bad_addr: cover property (@(posedge clk_sys) wb_err_o);
endmodule : ivp_top
`default_nettype wire

//--- testbench/ivp_core_model.sv
// Purpose: Core-side model that presents vector numbers and its execution space.
// Assumes: The vector address answers combinationally to the vector number.
// Notes: The global interrupt flag starts set and only set_state changes it, the block must never need to touch it.
`default_nettype none
module ivp_core_model (
   input wire logic clk_sys,
   input wire logic [11:0] vector_addr,
   output logic [4:0] vector_index,
   output logic exec_in_boot,
   output logic global_int_enable
);
   timeunit 1ns;
   timeprecision 1ns;
   // Start out in the application section with interrupts enabled.
   initial begin
      vector_index = 5'h00;
      exec_in_boot = 1'b0;
      global_int_enable = 1'b1;
   end
   // Presents a vector number after an edge and takes the address at the next edge.
   task automatic fetch(input logic [4:0] idx, output logic [11:0] addr);
      @(posedge clk_sys);
      vector_index <= idx;
      @(posedge clk_sys);
      addr = vector_addr;
   endtask : fetch
   // Moves the core between sections and sets its global flag after an edge.
   task automatic set_state(input logic boot, input logic gie);
      @(posedge clk_sys);
      exec_in_boot <= boot;
      global_int_enable <= gie;
   endtask : set_state
endmodule : ivp_core_model
`default_nettype wire

//--- testbench/testbench.sv
// Purpose: Self-checking bench for the vector placement block.
// Assumes: The master waits for ack or err, bounded only by the watchdog.
// Notes: Fuses are driven by the bench, the core side by the model.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0, srst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic wb_ack_o, wb_err_o, boot_reset_fuse = 1'b1, app_lk = 1'b1, boot_lk = 1'b1, er;
   logic [1:0] boot_size_fuses = 2'h0;
   logic exec_in_boot, global_int_enable, int_allow, vector_select;
   logic [4:0] vector_index;
   logic [11:0] vector_addr, reset_addr, va;
   int bad_count = 0, checks = 0;
   ivp_top dut (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
      .boot_reset_fuse(boot_reset_fuse), .boot_size_fuses(boot_size_fuses),
      .app_interrupt_lock_bit(app_lk), .boot_interrupt_lock_bit(boot_lk),
      .exec_in_boot(exec_in_boot), .global_int_enable(global_int_enable),
      .vector_index(vector_index), .vector_addr(vector_addr), .reset_addr(reset_addr),
      .int_allow(int_allow), .vector_select(vector_select));
   ivp_core_model core (.clk_sys(clk_sys), .vector_addr(vector_addr),
      .vector_index(vector_index), .exec_in_boot(exec_in_boot),
      .global_int_enable(global_int_enable));
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // The clock toggles every 25 ns, a period of 50 ns.
   initial begin
      forever #25 clk_sys = ~clk_sys;
   end
   // Compares one value and reports a mismatch at once.
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // One classic Wishbone cycle, held until ack or err is sampled high.
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, a, 4'hF, d};
      do begin
         @(posedge clk_sys);
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
      rd = wb_dat_o;
      er = wb_err_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask : wb
   // Two-step move of the table; interrupts drop with the enable write.
   task automatic mv(input logic s);
      wb(1'b1, ivp_pkg::IVP_VCR_ADDR, 32'h1);
      chk("allow_in_window", 0, int_allow);
      wb(1'b1, ivp_pkg::IVP_VCR_ADDR, {30'h0, s, 1'b0});
      chk("allow_hold", 0, int_allow);
      repeat (2) @(posedge clk_sys);
      chk("select", s, vector_select);
      chk("allow_after", 1, int_allow);
   endtask : mv
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   // Reset state and the table at flash start.
   task automatic t_reset;
      wb(1'b0, ivp_pkg::IVP_VCR_ADDR, 32'h0);
      chk("ctrl_reset", 32'h0, rd);
      chk("allow_reset", 1, int_allow);
      core.fetch(5'd18, va);
      chk("app_vec", 12'h012, va);
      chk("reset_app", 12'h000, reset_addr);
      $display("test reset done");
   endtask : t_reset
   // Moves to each boot size and back.
   task automatic t_move;
      logic [11:0] b[4];
      b = '{ivp_pkg::IVP_BOOT_2K, ivp_pkg::IVP_BOOT_1K, ivp_pkg::IVP_BOOT_512,
            ivp_pkg::IVP_BOOT_256};
      for (int s = 0; s < 4; s++) begin
         boot_size_fuses <= s[1:0];
         boot_reset_fuse <= 1'b0;
         mv(1'b1);
         core.fetch(5'd1, va);
         chk("boot_vec1", b[s] + 12'h001, va);
         core.fetch(5'd18, va);
         chk("boot_vec18", b[s] + 12'h012, va);
         chk("reset_boot", b[s], reset_addr);
         wb(1'b0, ivp_pkg::IVP_BASE_ADDR, 32'h0);
         chk("base_reg", {4'h0, b[s], 4'h0, b[s]}, rd);
         boot_reset_fuse <= 1'b1;
         mv(1'b0);
         core.fetch(5'd1, va);
         chk("app_vec1", 12'h001, va);
      end
      $display("test move done");
   endtask : t_move
   // Enable without select lapses after four cycles, then a late select is ignored.
   task automatic t_lapse;
      wb(1'b1, ivp_pkg::IVP_VCR_ADDR, 32'h1);
      chk("allow_lapse", 0, int_allow);
      repeat (3) begin
         @(posedge clk_sys);
         chk("allow_lapse", 0, int_allow);
      end
      @(posedge clk_sys);
      chk("allow_back", 1, int_allow);
      wb(1'b0, ivp_pkg::IVP_VCR_ADDR, 32'h0);
      chk("enable_clear", 32'h0, rd & 32'h3);
      wb(1'b1, ivp_pkg::IVP_VCR_ADDR, 32'h2);
      chk("late_select", 0, vector_select);
      wb(1'b1, ivp_pkg::IVP_VCR_ADDR, 32'h1);
      wb(1'b0, ivp_pkg::IVP_VCR_ADDR, 32'h0);
      chk("window_open", 32'h1, rd & 32'h3);
      repeat (4) @(posedge clk_sys);
      $display("test lapse done");
   endtask : t_lapse
   // Lock bits suppress interrupts in the other section.
   task automatic t_lock;
      boot_lk <= 1'b0;
      core.set_state(1'b1, 1'b1);
      repeat (2) @(posedge clk_sys);
      chk("boot_lock_boot", 0, int_allow);
      core.set_state(1'b0, 1'b1);
      repeat (2) @(posedge clk_sys);
      chk("boot_lock_app", 1, int_allow);
      boot_lk <= 1'b1;
      mv(1'b1);
      app_lk <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk("app_lock_app", 0, int_allow);
      wb(1'b0, ivp_pkg::IVP_STAT_ADDR, 32'h0);
      chk("status_reg", 32'h0000_001B, rd);
      core.set_state(1'b1, 1'b1);
      repeat (2) @(posedge clk_sys);
      chk("app_lock_boot", 1, int_allow);
      core.set_state(1'b1, 1'b0);
      repeat (2) @(posedge clk_sys);
      chk("gie_low", 0, int_allow);
      core.set_state(1'b1, 1'b1);
      repeat (2) @(posedge clk_sys);
      chk("gie_kept", 1, int_allow);
      wb(1'b0, 4'hC, 32'h0);
      chk("unmapped_err", 1, er);
      $display("test lock done");
   endtask : t_lock
   // A reset in mid-run brings the table back to flash start.
   task automatic t_rerst;
      @(posedge clk_sys);
      srst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      chk("select_rerst", 0, vector_select);
      chk("allow_rerst", 1, int_allow);
      wb(1'b0, ivp_pkg::IVP_VCR_ADDR, 32'h0);
      chk("ctrl_rerst", 32'h0, rd);
      $display("test rerst done");
   endtask : t_rerst
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test
   // Watchdog against a hung handshake.
   initial begin
      repeat (5000) @(posedge clk_sys);
      $display("ERROR watchdog expected finish seen timeout");
      bad_count++;
      stop_test();
   end
   // Main sequence.
   initial begin
      repeat (20) @(posedge clk_sys);
      srst <= 1'b0;
      t_reset();
      t_move();
      t_lapse();
      t_lock();
      t_rerst();
      stop_test();
   end
endmodule : testbench
`default_nettype wire
